//--- rtl/tc_defines.svh
// offsets, field positions, reset values and timing counts of the touch sequencer
`ifndef TC_DEFINES_SVH
`define TC_DEFINES_SVH

// ****************************************
// device register map (word addresses)
// ****************************************
`define TC_SETUP_FIRST  10'h000
`define TC_CAL_ADDR     10'h001
`define TC_STAT_A_ADDR  10'h008
`define TC_STAT_B_ADDR  10'h009
`define TC_STAT_C_ADDR  10'h00a
`define TC_CONV_FIRST   10'h00b
`define TC_CONV_LAST    10'h016
`define TC_ID_ADDR      10'h017
`define TC_CFG_FIRST    10'h080
`define TC_CFG_LAST     10'h0df
`define TC_RES_FIRST    10'h0e0
`define TC_RES_STRIDE   10'h024
`define TC_ADDR_MAX     10'h28f
`define TC_SETUP_WORDS  8
`define TC_CFG_WORDS    96
`define TC_CFG_PER_STG  8
`define TC_STAGES       12
// arbitrary identity value
`define TC_PART_ID      16'h5a3c

// ****************************************
// setup_control fields
// ****************************************
`define TC_MODE_LSB     0
`define TC_MODE_FULL    2'h0
`define TC_MODE_LOWP    2'h2
`define TC_STGNUM_LSB   4
`define TC_SWRST_BIT    10
`define TC_POL_BIT      11

// ****************************************
// power-up setup values
// ****************************************
`define TC_SETUP_V0     16'h00b2
`define TC_SETUP_V1     16'h0000
`define TC_SETUP_V2     16'h3230
`define TC_SETUP_V3     16'h14c8
`define TC_SETUP_V4     16'h0832
`define TC_SETUP_V5     16'h0000
`define TC_SETUP_V6     16'h0000
`define TC_SETUP_V7     16'h0001
`define TC_CAL_VALUE    16'h0fff
`define TC_WORD_RESET   16'h0000

// ****************************************
// timing
// ****************************************
`define TC_SEQ_MS       36
`define TC_CLK_KHZ      125000
`define TC_SEQ_CYCLES   (`TC_SEQ_MS * `TC_CLK_KHZ)

// ****************************************
// host controller apb map
// ****************************************
`define TC_APB_CTRL     12'h000
`define TC_APB_STATUS   12'h004
`define TC_APB_CFG      12'h008
`define TC_APB_LAST     12'h00c
`define TC_APB_IRQ_STAT 12'h010
`define TC_APB_IRQ_MASK 12'h014
`define TC_CTRL_START   0
`define TC_CTRL_POL     1

`endif

//--- rtl/tc_init_host.sv
// host end: apb-controlled power-up loader and interrupt status poller
//
// Summary of operation
// - load whole stage configuration bank first
// - then write eight setup words in order
// - calibration word stays zero in that burst
// - afterwards single write enabling calibration
// - device interrupts once per 36 ms sequence
// - on interrupt read selected status register
// - repeat status read on every interrupt
// - device address space split in three banks
// - result bank refreshed each sequence, readable
// - results valid only after configuration loaded
// - device pointer advances after each write
// - sixteen-bit registers, bytes sent in pairs
// - mode zero means full power, 36 ms
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tc_defines.svh"
module tc_init_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  tc_link_if.host          link
);
  import tc_pkg::*;

  tc_state_t state, next_state;
  tc_phase_t phase, next_phase;
  logic [6:0] widx, next_widx;
  tc_byte_t   out_byte, lo_byte, next_out_byte, next_lo_byte;
  tc_addr_t   txn_addr, next_txn_addr;
  tc_word_t   last_status, next_last_status, word, cfg_word, next_cfg_word;
  logic       cfg_full, next_cfg_full, start_req, next_start_req;
  logic       int_hi, next_int_hi, int_act, word_ok, last, cfg_take, start_take;
  logic [1:0] stat_sel, next_stat_sel, irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [1:0] done_set;
  logic [31:0] rd_mux, next_prdata;
  logic       acc, wr_done, rd_done, mapped;

  function automatic tc_word_t setup_word(input logic [2:0] i);
    unique case (i)
      3'h0: setup_word = `TC_SETUP_V0;
      3'h1: setup_word = `TC_SETUP_V1;
      3'h2: setup_word = `TC_SETUP_V2;
      3'h3: setup_word = `TC_SETUP_V3;
      3'h4: setup_word = `TC_SETUP_V4;
      3'h5: setup_word = `TC_SETUP_V5;
      3'h6: setup_word = `TC_SETUP_V6;
      3'h7: setup_word = `TC_SETUP_V7;
    endcase
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  assign int_act = int_hi ? link.int_out : ~link.int_out;

  always_comb begin
    next_state       = state;
    next_phase       = phase;
    next_widx        = widx;
    next_out_byte    = out_byte;
    next_lo_byte     = lo_byte;
    next_txn_addr    = txn_addr;
    next_last_status = last_status;
    done_set         = 2'b00;
    cfg_take         = 1'b0;
    start_take       = 1'b0;
    word             = `TC_CAL_VALUE;
    word_ok          = 1'b1;
    last             = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (start_req) begin
          start_take    = 1'b1;
          next_phase    = PH_CFG;
          next_widx     = 7'h00;
          next_txn_addr = `TC_CFG_FIRST;
          next_state    = ST_START;
        end
      end
      ST_START: begin
        next_state = (phase == PH_POLL) ? ST_RHI : ST_FETCH;
      end
      ST_FETCH: begin
        if (phase == PH_CFG) begin
          // waits on software so the bank is streamed as one burst
          word     = cfg_word;
          word_ok  = cfg_full;
          cfg_take = cfg_full;
        end else if (phase == PH_SETUP) begin
          word = setup_word(widx[2:0]);
        end
        if (word_ok) begin
          next_out_byte = word[15:8];
          next_lo_byte  = word[7:0];
          next_state    = ST_HI;
        end
      end
      ST_HI: begin
        if (link.byte_ack) begin
          next_out_byte = lo_byte;
          next_state    = ST_LO;
        end
      end
      ST_LO: begin
        if (link.byte_ack) begin
          next_widx = widx + 7'h01;
          last = (phase == PH_CAL)
              || (phase == PH_CFG && widx == 7'(`TC_CFG_WORDS - 1))
              || (phase == PH_SETUP && widx == 7'(`TC_SETUP_WORDS - 1));
          if (!last) begin
            next_state = ST_FETCH;
          end else if (phase == PH_CFG) begin
            next_phase    = PH_SETUP;
            next_widx     = 7'h00;
            next_txn_addr = `TC_SETUP_FIRST;
            next_state    = ST_START;
          end else if (phase == PH_SETUP) begin
            next_phase    = PH_CAL;
            next_txn_addr = `TC_CAL_ADDR;
            next_state    = ST_START;
          end else begin
            next_phase  = PH_POLL;
            done_set[0] = 1'b1;
            next_state  = ST_WAIT_INT;
          end
        end
      end
      ST_WAIT_INT: begin
        if (int_act) begin
          next_txn_addr = `TC_STAT_A_ADDR + 10'(stat_sel);
          next_state    = ST_START;
        end
      end
      ST_RHI: begin
        if (link.byte_ack) begin
          next_last_status[15:8] = link.rdata;
          next_state             = ST_RLO;
        end
      end
      ST_RLO: begin
        if (link.byte_ack) begin
          next_last_status[7:0] = link.rdata;
          done_set[1]           = 1'b1;
          next_state            = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        // the read clears the source only when stat_sel picks it (stat_c here); wait for the level to drop first
        if (!int_act) begin
          next_state = ST_WAIT_INT;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      phase       <= PH_CFG;
      widx        <= 7'h00;
      out_byte    <= 8'h00;
      lo_byte     <= 8'h00;
      txn_addr    <= `TC_SETUP_FIRST;
      last_status <= `TC_WORD_RESET;
    end else begin
      state       <= next_state;
      phase       <= next_phase;
      widx        <= next_widx;
      out_byte    <= next_out_byte;
      lo_byte     <= next_lo_byte;
      txn_addr    <= next_txn_addr;
      last_status <= next_last_status;
    end
  end

  assign link.txn_start  = (state == ST_START);
  assign link.txn_addr   = txn_addr;
  assign link.byte_valid = (state == ST_HI) || (state == ST_LO)
                        || (state == ST_RHI) || (state == ST_RLO);
  assign link.byte_write = (state == ST_HI) || (state == ST_LO);
  assign link.wdata      = out_byte;

  // ****************************************
  // apb slave
  // ****************************************
  assign mapped  = (paddr == `TC_APB_CTRL) || (paddr == `TC_APB_STATUS)
                || (paddr == `TC_APB_CFG) || (paddr == `TC_APB_LAST)
                || (paddr == `TC_APB_IRQ_STAT) || (paddr == `TC_APB_IRQ_MASK);
  // a config word write stalls until the sequencer has fetched the previous one
  assign pready  = !(psel && paddr == `TC_APB_CFG && pwrite && cfg_full);
  assign acc     = psel && penable && pready;
  assign wr_done = acc && pwrite && mapped;
  assign rd_done = acc && !pwrite && paddr == `TC_APB_IRQ_STAT;
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(irq_stat & irq_mask);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `TC_APB_CTRL:     rd_mux = {28'h0, stat_sel, int_hi, 1'b0};
      `TC_APB_STATUS:   rd_mux = {29'h0, cfg_full, phase == PH_POLL, state != ST_IDLE};
      `TC_APB_LAST:     rd_mux = {16'h0, last_status};
      `TC_APB_IRQ_STAT: rd_mux = {30'h0, irq_stat};
      `TC_APB_IRQ_MASK: rd_mux = {30'h0, irq_mask};
      default:          rd_mux = 32'h0000_0000;
    endcase
    next_prdata    = (psel && !penable) ? rd_mux : prdata;
    next_int_hi    = int_hi;
    next_stat_sel  = stat_sel;
    next_irq_mask  = irq_mask;
    next_cfg_word  = cfg_word;
    next_cfg_full  = cfg_full && !cfg_take;
    next_start_req = start_req && !start_take;
    if (wr_done && paddr == `TC_APB_CTRL) begin
      next_int_hi    = pwdata[`TC_CTRL_POL];
      next_stat_sel  = pwdata[3:2];
      next_start_req = next_start_req || (pwdata[`TC_CTRL_START] && state == ST_IDLE);
    end
    if (wr_done && paddr == `TC_APB_CFG) begin
      next_cfg_word = pwdata[15:0];
      next_cfg_full = 1'b1;
    end
    if (wr_done && paddr == `TC_APB_IRQ_MASK) begin
      next_irq_mask = pwdata[1:0];
    end
    // only reported bits are cleared and a new event still sets
    next_irq_stat = (irq_stat & ~(rd_done ? prdata[1:0] : 2'b00)) | done_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0000_0000;
      int_hi    <= 1'b0;
      stat_sel  <= 2'b00;
      irq_mask  <= 2'b00;
      irq_stat  <= 2'b00;
      cfg_word  <= `TC_WORD_RESET;
      cfg_full  <= 1'b0;
      start_req <= 1'b0;
    end else begin
      prdata    <= next_prdata;
      int_hi    <= next_int_hi;
      stat_sel  <= next_stat_sel;
      irq_mask  <= next_irq_mask;
      irq_stat  <= next_irq_stat;
      cfg_word  <= next_cfg_word;
      cfg_full  <= next_cfg_full;
      start_req <= next_start_req;
    end
  end
endmodule
`default_nettype wire

//--- rtl/tc_link_if.sv
// byte link between the sequencing host and the touch device
`timescale 1ns/1ps
`default_nettype none
interface tc_link_if;
  import tc_pkg::*;
  logic     txn_start;
  tc_addr_t txn_addr;
  logic     byte_valid;
  logic     byte_write;
  tc_byte_t wdata;
  logic     byte_ack;
  tc_byte_t rdata;
  logic     int_out;
  modport dev  (input txn_start, txn_addr, byte_valid, byte_write, wdata,
                output byte_ack, rdata, int_out);
  modport host (output txn_start, txn_addr, byte_valid, byte_write, wdata,
                input byte_ack, rdata, int_out);
endinterface
`default_nettype wire

//--- rtl/tc_pkg.sv
// types shared by both ends of the touch sequencer link
package tc_pkg;
  typedef logic [15:0] tc_word_t;
  typedef logic [9:0]  tc_addr_t;
  typedef logic [7:0]  tc_byte_t;
  typedef enum logic [1:0] {PH_CFG, PH_SETUP, PH_CAL, PH_POLL} tc_phase_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_FETCH, ST_HI, ST_LO, ST_WAIT_INT, ST_RHI, ST_RLO, ST_CLEAR
  } tc_state_t;
endpackage

//--- rtl/tc_sensor_dev.sv
// touch device end: banked registers, pointer, sequence timer, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "tc_defines.svh"
module tc_sensor_dev #(
  parameter int unsigned SEQ_CYCLES = `TC_SEQ_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  tc_link_if.dev    link,
  output logic      seq_done,
  output logic      results_valid
);
  import tc_pkg::*;
  localparam int CW = $clog2(SEQ_CYCLES + 1);

  tc_word_t setup [`TC_SETUP_WORDS];
  tc_word_t cfg   [`TC_CFG_WORDS];
  tc_word_t result[`TC_STAGES];
  tc_word_t next_setup [`TC_SETUP_WORDS];
  tc_word_t next_cfg   [`TC_CFG_WORDS];
  tc_word_t next_result[`TC_STAGES];
  tc_word_t stat_a, stat_c, seq_num, rd_word, next_stat_a, next_stat_c, next_seq_num;
  tc_addr_t ptr, next_ptr, aoff, woff;
  tc_byte_t hi_hold, lo_hold, rdata, next_hi_hold, next_lo_hold, next_rdata;
  logic     second, over, ack, int_out, cfg_ok, seq_ev, pend;
  logic     next_second, next_over, next_ack, next_int_out, next_cfg_ok, next_seq_done;
  logic [CW-1:0] seq_cnt, next_seq_cnt;
  logic [4:0]    n_stages;

  // ****************************************
  // read decode of the three banks
  // ****************************************
  always_comb begin
    rd_word = `TC_WORD_RESET;
    aoff    = ptr;
    if (ptr < 10'(`TC_SETUP_WORDS)) begin
      rd_word = setup[ptr[2:0]];
    end else if (ptr == `TC_STAT_A_ADDR) begin
      rd_word = stat_a;
    end else if (ptr == `TC_STAT_C_ADDR) begin
      rd_word = stat_c;
    end else if (ptr == `TC_ID_ADDR) begin
      rd_word = `TC_PART_ID;
    end else if (ptr >= `TC_CONV_FIRST && ptr <= `TC_CONV_LAST) begin
      aoff    = ptr - `TC_CONV_FIRST;
      rd_word = result[aoff[3:0]];
    end else if (ptr >= `TC_CFG_FIRST && ptr <= `TC_CFG_LAST) begin
      aoff    = ptr - `TC_CFG_FIRST;
      rd_word = cfg[aoff[6:0]];
    end else begin
      for (int s = 0; s < `TC_STAGES; s++) begin
        if (ptr == 10'(`TC_RES_FIRST + s * `TC_RES_STRIDE)) begin
          rd_word = result[s];
        end
      end
    end
  end

  // ****************************************
  // link, registers, sequence timer
  // ****************************************
  always_comb begin
    next_setup    = setup;
    next_cfg      = cfg;
    next_result   = result;
    next_stat_a   = stat_a;
    next_stat_c   = stat_c;
    next_seq_num  = seq_num;
    next_ptr      = ptr;
    next_hi_hold  = hi_hold;
    next_lo_hold  = lo_hold;
    next_rdata    = rdata;
    next_second   = second;
    next_over     = over;
    next_ack      = 1'b0;
    next_cfg_ok   = cfg_ok;
    next_seq_cnt  = seq_cnt;
    seq_ev        = 1'b0;
    woff          = ptr - `TC_CFG_FIRST;
    if (link.txn_start) begin
      next_ptr    = link.txn_addr;
      next_second = 1'b0;
      next_over   = 1'b0;
    end else if (link.byte_valid && !ack) begin
      next_ack = 1'b1;
      if (link.byte_write) begin
        if (!second) begin
          next_hi_hold = link.wdata;
          next_second  = 1'b1;
        end else begin
          next_second = 1'b0;
          if (!over) begin
            if (ptr < 10'(`TC_SETUP_WORDS)) begin
              next_setup[ptr[2:0]] = {hi_hold, link.wdata};
              if (ptr == `TC_SETUP_FIRST && hi_hold[`TC_SWRST_BIT - 8]) begin
                // software reset self-clears: the eight setup words back to defaults
                for (int i = 0; i < `TC_SETUP_WORDS; i++) begin
                  next_setup[i] = `TC_WORD_RESET;
                end
              end
            end else if (ptr >= `TC_CFG_FIRST && ptr <= `TC_CFG_LAST) begin
              next_cfg[woff[6:0]] = {hi_hold, link.wdata};
              if (ptr == `TC_CFG_LAST) begin
                next_cfg_ok = 1'b1;
              end
            end
            // past the top the pointer parks and later words are dropped
            if (ptr == `TC_ADDR_MAX) begin
              next_over = 1'b1;
            end else begin
              next_ptr = ptr + 10'h001;
            end
          end
        end
      end else begin
        if (!second) begin
          next_rdata   = rd_word[15:8];
          next_lo_hold = rd_word[7:0];
          next_second  = 1'b1;
          if (ptr == `TC_STAT_A_ADDR) begin
            next_stat_a = `TC_WORD_RESET;
          end
          if (ptr == `TC_STAT_C_ADDR) begin
            next_stat_c = `TC_WORD_RESET;
          end
        end else begin
          next_rdata  = lo_hold;
          next_second = 1'b0;
          if (ptr != `TC_ADDR_MAX) begin
            next_ptr = ptr + 10'h001;
          end
        end
      end
    end
    // wake-up mode keeps the sequence running; only the shutdown codes stop it
    if (setup[0][`TC_MODE_LSB +: 2] == `TC_MODE_FULL
        || setup[0][`TC_MODE_LSB +: 2] == `TC_MODE_LOWP) begin
      if (seq_cnt == CW'(SEQ_CYCLES - 1)) begin
        next_seq_cnt = '0;
        seq_ev       = 1'b1;
      end else begin
        next_seq_cnt = seq_cnt + 1'b1;
      end
    end else begin
      next_seq_cnt = '0;
    end
    n_stages = 5'(setup[0][`TC_STGNUM_LSB +: 4]) + 5'h01;
    if (seq_ev) begin
      // set after the read clear so a same-cycle event survives
      next_stat_c[0] = 1'b1;
      next_seq_num   = seq_num + 16'h0001;
      for (int s = 0; s < `TC_STAGES; s++) begin
        if (cfg_ok && 5'(s) < n_stages) begin
          next_result[s] = cfg[s * `TC_CFG_PER_STG] ^ seq_num;
          next_stat_a[s] = 1'b1;
        end
      end
    end
    pend         = |(stat_a & setup[5]) | |(stat_c & setup[7]);
    next_int_out = setup[0][`TC_POL_BIT] ? pend : ~pend;
    next_seq_done = seq_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `TC_SETUP_WORDS; i++) setup[i] <= `TC_WORD_RESET;
      for (int i = 0; i < `TC_CFG_WORDS; i++) cfg[i] <= `TC_WORD_RESET;
      for (int i = 0; i < `TC_STAGES; i++) result[i] <= `TC_WORD_RESET;
      stat_a        <= `TC_WORD_RESET;
      stat_c        <= `TC_WORD_RESET;
      seq_num       <= `TC_WORD_RESET;
      ptr           <= `TC_SETUP_FIRST;
      hi_hold       <= 8'h00;
      lo_hold       <= 8'h00;
      rdata         <= 8'h00;
      second        <= 1'b0;
      over          <= 1'b0;
      ack           <= 1'b0;
      int_out       <= 1'b1;
      cfg_ok        <= 1'b0;
      seq_cnt       <= '0;
      seq_done      <= 1'b0;
    end else begin
      setup         <= next_setup;
      cfg           <= next_cfg;
      result        <= next_result;
      stat_a        <= next_stat_a;
      stat_c        <= next_stat_c;
      seq_num       <= next_seq_num;
      ptr           <= next_ptr;
      hi_hold       <= next_hi_hold;
      lo_hold       <= next_lo_hold;
      rdata         <= next_rdata;
      second        <= next_second;
      over          <= next_over;
      ack           <= next_ack;
      int_out       <= next_int_out;
      cfg_ok        <= next_cfg_ok;
      seq_cnt       <= next_seq_cnt;
      seq_done      <= next_seq_done;
    end
  end

  assign link.byte_ack = ack;
  assign link.rdata    = rdata;
  assign link.int_out  = int_out;
  assign results_valid = cfg_ok;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench: apb-driven host end loading and polling the device end
`timescale 1ns/1ps
`default_nettype none
`include "tc_defines.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam logic [32:0] ALL = 33'h1ffffffff;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, seq_done, results_valid;
  logic        seq_on = 1'b0;
  logic [15:0] rnd = 16'h005f;
  logic [32:0] q_exp[$], q_msk[$], e, m;
  int          n_mismatch = 0;
  int          checked = 0;
  int          gap = 0;
  tc_link_if tc_link_if_inst ();
  tc_sensor_dev #(.SEQ_CYCLES(200)) tc_sensor_dev_inst (.pclk(pclk), .presetn(presetn),
    .link(tc_link_if_inst), .seq_done(seq_done), .results_valid(results_valid));
  tc_init_host tc_init_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(tc_link_if_inst));
  tc_link_sva tc_link_sva_inst (.pclk(pclk), .presetn(presetn),
    .txn_start(tc_link_if_inst.txn_start), .txn_addr(tc_link_if_inst.txn_addr),
    .byte_valid(tc_link_if_inst.byte_valid), .byte_write(tc_link_if_inst.byte_write),
    .wdata(tc_link_if_inst.wdata), .byte_ack(tc_link_if_inst.byte_ack),
    .rdata(tc_link_if_inst.rdata), .int_out(tc_link_if_inst.int_out));
  always #4 pclk = ~pclk;
  // ****************************************
  // tasks and monitors
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // reads note {pslverr, prdata} expectation and mask for the monitor
  task automatic apb(input logic [11:0] a, input logic w, input logic [32:0] d,
                     input logic [32:0] mk);
    if (!w) begin
      q_exp.push_back(d);
      q_msk.push_back(mk);
    end
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 3000 && irq !== lvl; i++) @(posedge pclk);
    `CHK(irq, lvl)
  endtask
  task automatic summarize();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      m = q_msk.pop_front();
      e = q_exp.pop_front();
      `CHK({pslverr, prdata} & m, e)
    end
    // sequence spacing only once polling runs, timer may restart during setup
    if (seq_done === 1'b1) begin
      if (seq_on && gap != 0) `CHK(gap, 200)
      gap <= 1;
    end else if (gap != 0) begin
      gap <= gap + 1;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(results_valid, 1'b0)
    apb(`TC_APB_CTRL, 1'b0, 33'h0, ALL);
    apb(`TC_APB_STATUS, 1'b0, 33'h0, ALL);
    apb(`TC_APB_IRQ_MASK, 1'b0, 33'h0, ALL);
    apb(12'h020, 1'b0, 33'h100000000, ALL);
    apb(`TC_APB_IRQ_MASK, 1'b1, 33'h1, 33'h0);
    apb(`TC_APB_CTRL, 1'b1, 33'h9, 33'h0);
    apb(`TC_APB_CTRL, 1'b0, 33'h8, 33'hf);
    apb(`TC_APB_STATUS, 1'b0, 33'h1, 33'h1);
    for (int i = 0; i < 96; i++) begin
      rnd = lfsr(rnd);
      apb(`TC_APB_CFG, 1'b1, {17'h0, rnd}, 33'h0);
    end
    wait_irq(1'b1);
    apb(`TC_APB_IRQ_STAT, 1'b0, 33'h1, 33'h1);
    wait_irq(1'b0);
    `CHK(results_valid, 1'b1)
    apb(`TC_APB_IRQ_MASK, 1'b1, 33'h2, 33'h0);
    for (int k = 0; k < 3; k++) begin
      wait_irq(1'b1);
      seq_on <= 1'b1;
      apb(`TC_APB_LAST, 1'b0, 33'h1, 33'hffff);
      apb(`TC_APB_IRQ_STAT, 1'b0, 33'h2, 33'h2);
      wait_irq(1'b0);
    end
    summarize();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire

//--- verification/tc_link_sva.sv
// protocol and power-up order checks on the host to device byte link
`timescale 1ns/1ps
`default_nettype none
module tc_link_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       txn_start,
  input wire logic [9:0] txn_addr,
  input wire logic       byte_valid,
  input wire logic       byte_write,
  input wire logic [7:0] wdata,
  input wire logic       byte_ack,
  input wire logic [7:0] rdata,
  input wire logic       int_out
);
  // ****************************************
  // pointer tracking
  // ****************************************
  localparam logic [15:0] SETUP [8] = '{16'h00b2, 16'h0000, 16'h3230, 16'h14c8,
                                        16'h0832, 16'h0000, 16'h0000, 16'h0001};
  logic [9:0] ptr, base, next_ptr, next_base;
  // flags: low byte due, config done, setup done, calibration done
  logic [3:0] flg, next_flg;
  logic       wr_end;
  assign wr_end = byte_ack & byte_write & flg[0];
  always_comb begin
    next_base   = txn_start ? txn_addr : base;
    next_ptr    = txn_start ? txn_addr : ptr + 10'(byte_ack & flg[0]);
    next_flg[0] = txn_start ? 1'b0 : flg[0] ^ byte_ack;
    next_flg[1] = flg[1] | (wr_end & (ptr == 10'h0df));
    next_flg[2] = flg[2] | (wr_end & (ptr == 10'h007) & flg[1]);
    next_flg[3] = flg[3] | (wr_end & flg[2]);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ptr, base, flg} <= '0;
    end else begin
      {ptr, base, flg} <= {next_ptr, next_base, next_flg};
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_after_valid: assert property ($rose(byte_valid) |=> byte_ack)
    else $error("byte not acknowledged one cycle after valid");
  a_ack_single: assert property (byte_ack |=> !byte_ack)
    else $error("acknowledge longer than one cycle");
  a_ack_has_req: assert property (byte_ack |-> $past(byte_valid))
    else $error("acknowledge without a byte request");
  a_req_held: assert property (
    byte_valid && !byte_ack |=> byte_valid && $stable({byte_write, wdata}))
    else $error("byte request changed before acknowledge");
  a_start_idle: assert property (txn_start |-> !byte_valid)
    else $error("pointer load during a byte transfer");
  a_cfg_first: assert property (
    byte_valid && byte_write && !flg[1] |-> ptr >= 10'h080 && ptr <= 10'h0df)
    else $error("write outside config bank before it is loaded");
  a_setup_vals: assert property (
    byte_valid && byte_write && flg[1] && !flg[2] |-> ptr < 10'h008
      && wdata == (flg[0] ? SETUP[ptr[2:0]][7:0] : SETUP[ptr[2:0]][15:8]))
    else $error("setup burst byte wrong");
  a_cal_single: assert property (
    byte_valid && byte_write && flg[2] |-> !flg[3] && ptr == 10'h001
      && wdata == (flg[0] ? 8'hff : 8'h0f))
    else $error("calibration write wrong or repeated");
  a_read_after_init: assert property (
    byte_valid && !byte_write |-> flg[3] && base >= 10'h008 && base <= 10'h00b)
    else $error("status read before init or at wrong address");
  c_cal_write: cover property (wr_end && flg[2]);
  c_status_read: cover property (byte_ack && !byte_write);
  c_int_active: cover property ($fell(int_out));
endmodule
`default_nettype wire
